/* File: verilog/per_channel_idle_and_block_ctrl.v */
// per-channel idle code substitution and channel blocking outputs,
// with a 16-word fifo on each data path and an avalon-mm register slave
// assumes framer channel indices 0..31 arrive synchronous to clk_sys
//
// Summary of operation
// - A transmit byte whose channel enable bit is set is replaced by its idle array entry, else passed as is.
// - A receive byte whose channel enable bit is set is replaced by its idle array entry, else passed as is.
// - Transmit enables for channels 9 to 16 sit in bits 0 to 7 of the second transmit enable register.
// - Transmit enables for channels 17 to 24 and 25 to 32 sit at 82h and 83h, bit 0 lowest channel.
// - Receive enables for channels 1 to 32 sit at 84h to 87h, eight per register, bit 0 lowest.
// - The receive block output is high through a channel time whose blocking bit is 1, else low.
// - The transmit block output is high through a channel time whose blocking bit is 1, else low.
// - Receive blocking bits for channels 1 to 32 sit at 88h to 8bh, bit 0 lowest of each group.
// - Transmit blocking bits for channels 1 to 32 sit at 8ch to 8fh, bit 0 lowest of each group.
// - In T1 mode blocking bits for channels 25 to 32 are ignored.
// - In T1 mode idle substitution applies to the first 24 channels only.
// - Idle codes come from a 64-byte array, 0..31 transmit and 32..63 receive.
`timescale 1ns/10ps
`include "idle_block_map.vh"

// ==========================================================
// fifo with registered output stage
module chan_byte_fifo #(
  parameter WIDTH = 13,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk_sys,
  input  wire             rst,
  input  wire             in_valid,
  output reg              in_ready,
  input  wire [WIDTH-1:0] in_data,
  output reg              out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data
);

  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wr_ptr_q;
  reg  [AW-1:0]    rd_ptr_q;
  reg  [AW:0]      cnt_q;
  reg  [AW:0]      cnt_d;
  wire             push;
  wire             pop;

  // push on accepted input, pop into output register when free
  assign push = in_valid & in_ready;
  assign pop  = (cnt_q != {(AW+1){1'b0}}) & (~out_valid | out_ready);

  // occupancy next value
  always @*
  begin
    cnt_d = cnt_q;
    if (push & ~pop)
      cnt_d = cnt_q + {{AW{1'b0}}, 1'b1};
    else if (pop & ~push)
      cnt_d = cnt_q - {{AW{1'b0}}, 1'b1};
  end

  // storage, no reset needed
  always @(posedge clk_sys)
  begin
    if (push)
      mem[wr_ptr_q] <= in_data;
  end

  // pointers, count, ready and output stage
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr_q  <= {AW{1'b0}};
      rd_ptr_q  <= {AW{1'b0}};
      cnt_q     <= {(AW+1){1'b0}};
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
      out_data  <= {WIDTH{1'b0}};
    end
    else
    begin
      cnt_q    <= cnt_d;
      in_ready <= (cnt_d != DEPTH); // back-pressure to the source
      if (push)
        wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      if (pop)
      begin
        rd_ptr_q  <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
        out_data  <= mem[rd_ptr_q];
        out_valid <= 1'b1;
      end
      else if (out_ready)
        out_valid <= 1'b0;
    end
  end

endmodule

// ==========================================================
// idle code choice for one direction, ahead of its fifo
module idle_code_sel #(
  parameter NCH = 32
) (
  input  wire [NCH-1:0] en_bits,
  input  wire           t1_mode,
  input  wire [4:0]     chan,
  input  wire [7:0]     data_in,
  input  wire [7:0]     idle_code,
  output wire [7:0]     data_out
);

  wire chan_live;

  // channels past 24 have no time slot in t1 mode
  assign chan_live = ~t1_mode | (chan <= `T1_LAST_CHAN);
  // an enabled live channel carries the idle code, others pass
  // purely combinational: the fifo input stage registers the result
  assign data_out  = (en_bits[chan] & chan_live) ? idle_code : data_in;

endmodule

// ==========================================================
// top: register bank, idle array, substitution, block outputs
module per_channel_idle_and_block_ctrl #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW    = 4
) (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire [9:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire        tx_chan_start,
  input  wire [4:0]  tx_chan_idx,
  input  wire        rx_chan_start,
  input  wire [4:0]  rx_chan_idx,
  input  wire        tx_in_valid,
  output wire        tx_in_ready,
  input  wire [7:0]  tx_in_data,
  input  wire [4:0]  tx_in_chan,
  output wire        tx_out_valid,
  input  wire        tx_out_ready,
  output wire [7:0]  tx_out_data,
  output wire [4:0]  tx_out_chan,
  input  wire        rx_in_valid,
  output wire        rx_in_ready,
  input  wire [7:0]  rx_in_data,
  input  wire [4:0]  rx_in_chan,
  output wire        rx_out_valid,
  input  wire        rx_out_ready,
  output wire [7:0]  rx_out_data,
  output wire [4:0]  rx_out_chan,
  output reg         tx_channel_block_out,
  output reg         rx_channel_block_out
);

  // ========================================================
  // register state
  reg  [31:0] tx_en_q;
  reg  [31:0] rx_en_q;
  reg  [31:0] rx_blk_q;
  reg  [31:0] tx_blk_q;
  reg  [7:0]  idle_array [0:63];
  reg  [5:0]  idle_ptr_q;
  reg         t1_mode_q;
  reg  [4:0]  tx_chan_q;
  reg  [4:0]  rx_chan_q;
  reg  [31:0] rd_val;
  reg  [7:0]  bank_byte;
  wire [7:0]  reg_idx;
  wire        in_bank;
  wire        req;
  wire        wr_go;
  wire [4:0]  bit_sel;
  integer     i;

  // ========================================================
  // bus decode
  assign reg_idx = avs_address[9:2];
  assign in_bank = (reg_idx[7:4] == 4'h8);
  assign req     = avs_read | avs_write;
  assign wr_go   = avs_write & ~avs_waitrequest; // write lands at the accepting edge
  assign bit_sel = {reg_idx[1:0], 3'b000};

  // byte of the 80h..8fh bank at the addressed index
  always @*
  begin
    case (reg_idx[3:2])
      `GRP_TX_EN:  bank_byte = tx_en_q[bit_sel +: 8];
      `GRP_RX_EN:  bank_byte = rx_en_q[bit_sel +: 8];
      `GRP_RX_BLK: bank_byte = rx_blk_q[bit_sel +: 8];
      `GRP_TX_BLK: bank_byte = tx_blk_q[bit_sel +: 8];
      default:     bank_byte = `RST_REG8;
    endcase
  end

  // read value, unmapped reads as zero
  always @*
  begin
    rd_val = 32'h0000_0000;
    if (in_bank)
      rd_val = {24'h00_0000, bank_byte};
    else if (reg_idx == `IDX_IDLE_PTR)
      rd_val = {26'h000_0000, idle_ptr_q};
    else if (reg_idx == `IDX_IDLE_CODE)
      rd_val = {24'h00_0000, idle_array[idle_ptr_q]};
    else if (reg_idx == `IDX_MODE)
      rd_val = {31'h0000_0000, t1_mode_q};
    else if (reg_idx == `IDX_CHAN_STATUS)
      rd_val = {19'h0_0000, rx_chan_q, 3'h0, tx_chan_q};
  end

  // ========================================================
  // avalon handshake: one wait cycle, then accept
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end
    else
    begin
      if (req & avs_waitrequest)
      begin
        avs_waitrequest <= 1'b0;
        avs_readdata    <= rd_val;
      end
      else
        avs_waitrequest <= 1'b1;
    end
  end

  // ========================================================
  // control register writes
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      tx_en_q    <= 32'h0000_0000;
      rx_en_q    <= 32'h0000_0000;
      rx_blk_q   <= 32'h0000_0000;
      tx_blk_q   <= 32'h0000_0000;
      idle_ptr_q <= 6'h00;
      t1_mode_q  <= `RST_MODE;
    end
    else if (wr_go)
    begin
      if (in_bank)
      begin
        case (reg_idx[3:2])
          `GRP_TX_EN:  tx_en_q[bit_sel +: 8]  <= avs_writedata[7:0];
          `GRP_RX_EN:  rx_en_q[bit_sel +: 8]  <= avs_writedata[7:0];
          `GRP_RX_BLK: rx_blk_q[bit_sel +: 8] <= avs_writedata[7:0];
          `GRP_TX_BLK: tx_blk_q[bit_sel +: 8] <= avs_writedata[7:0];
          default:     tx_en_q <= tx_en_q;
        endcase
      end
      else if (reg_idx == `IDX_IDLE_PTR)
        idle_ptr_q <= avs_writedata[5:0];
      else if (reg_idx == `IDX_MODE)
        t1_mode_q <= avs_writedata[`MODE_T1_BIT];
    end
  end

  // idle code array, cleared at reset
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      for (i = 0; i < 64; i = i + 1)
        idle_array[i] <= `RST_REG8;
    end
    else if (wr_go & (reg_idx == `IDX_IDLE_CODE))
      idle_array[idle_ptr_q] <= avs_writedata[7:0];
  end

  // ========================================================
  // substitution on the way into each fifo
  wire [7:0] tx_idle;
  wire [7:0] rx_idle;
  wire [7:0] tx_sub;
  wire [7:0] rx_sub;

  // transmit uses entries 0..31, receive 32..63
  assign tx_idle = idle_array[{1'b0, tx_in_chan}];
  assign rx_idle = idle_array[{`RX_ARRAY_BASE, rx_in_chan}];

  // transmit channel selection
  idle_code_sel #(
    .NCH (32)
  ) u_tx_sel (
    .en_bits   (tx_en_q),
    .t1_mode   (t1_mode_q),
    .chan      (tx_in_chan),
    .data_in   (tx_in_data),
    .idle_code (tx_idle),
    .data_out  (tx_sub)
  );

  // receive channel selection
  idle_code_sel #(
    .NCH (32)
  ) u_rx_sel (
    .en_bits   (rx_en_q),
    .t1_mode   (t1_mode_q),
    .chan      (rx_in_chan),
    .data_in   (rx_in_data),
    .idle_code (rx_idle),
    .data_out  (rx_sub)
  );

  // transmit data fifo
  chan_byte_fifo #(
    .WIDTH (13),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_tx_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (tx_in_valid),
    .in_ready  (tx_in_ready),
    .in_data   ({tx_in_chan, tx_sub}),
    .out_valid (tx_out_valid),
    .out_ready (tx_out_ready),
    .out_data  ({tx_out_chan, tx_out_data})
  );

  // receive data fifo
  chan_byte_fifo #(
    .WIDTH (13),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_rx_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (rx_in_valid),
    .in_ready  (rx_in_ready),
    .in_data   ({rx_in_chan, rx_sub}),
    .out_valid (rx_out_valid),
    .out_ready (rx_out_ready),
    .out_data  ({rx_out_chan, rx_out_data})
  );

  // ========================================================
  // channel block outputs, changed only at channel boundaries
  // held for the whole channel time so a controller can gate its clock
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      tx_channel_block_out <= 1'b0;
      rx_channel_block_out <= 1'b0;
      tx_chan_q            <= 5'h00;
      rx_chan_q            <= 5'h00;
    end
    else
    begin
      if (tx_chan_start)
      begin
        tx_chan_q            <= tx_chan_idx;
        tx_channel_block_out <= tx_blk_q[tx_chan_idx]
                                & ~(t1_mode_q & (tx_chan_idx > `T1_LAST_CHAN));
      end
      if (rx_chan_start)
      begin
        rx_chan_q            <= rx_chan_idx;
        rx_channel_block_out <= rx_blk_q[rx_chan_idx]
                                & ~(t1_mode_q & (rx_chan_idx > `T1_LAST_CHAN));
      end
    end
  end

endmodule

/* File: verilog/idle_block_map.vh */
// register map, field layout, reset values and timing figures
// assumes 32-bit avalon-mm data with one register per aligned word
`ifndef IDLE_BLOCK_MAP_VH
`define IDLE_BLOCK_MAP_VH

// ==========================================================
// register indices (byte address = 4 * index)
`define IDX_TX_EN_CH1_8      8'h80
`define IDX_TX_EN_CH9_16     8'h81
`define IDX_TX_EN_CH17_24    8'h82
`define IDX_TX_EN_CH25_32    8'h83
`define IDX_RX_EN_CH1_8      8'h84
`define IDX_RX_EN_CH9_16     8'h85
`define IDX_RX_EN_CH17_24    8'h86
`define IDX_RX_EN_CH25_32    8'h87
`define IDX_RX_BLK_CH1_8     8'h88
`define IDX_RX_BLK_CH9_16    8'h89
`define IDX_RX_BLK_CH17_24   8'h8a
`define IDX_RX_BLK_CH25_32   8'h8b
`define IDX_TX_BLK_CH1_8     8'h8c
`define IDX_TX_BLK_CH9_16    8'h8d
`define IDX_TX_BLK_CH17_24   8'h8e
`define IDX_TX_BLK_CH25_32   8'h8f
`define IDX_IDLE_PTR         8'h7e
`define IDX_IDLE_CODE        8'h7f
`define IDX_MODE             8'h90
`define IDX_CHAN_STATUS      8'h91

// ==========================================================
// groups inside the 80h..8fh bank, selected by index bits 3:2
`define GRP_TX_EN            2'h0
`define GRP_RX_EN            2'h1
`define GRP_RX_BLK           2'h2
`define GRP_TX_BLK           2'h3

// ==========================================================
// fields
`define MODE_T1_BIT          0
`define IDLE_PTR_W           6
`define RX_ARRAY_BASE        1'b1
`define T1_LAST_CHAN         5'h17

// ==========================================================
// reset values
`define RST_REG8             8'h00
`define RST_MODE             1'b0

// ==========================================================
// bus timing in clk_sys cycles
`define BUS_WAIT_CYCLES      1

`endif

/* File: tb/idle_block_assertions.sv */
// checker on top ports: bus handshake, block outputs, stream hold
// assumes it is bound to per_channel_idle_and_block_ctrl
`timescale 1ns/10ps
module idle_block_assertions (
  input wire        clk_sys,
  input wire        rst,
  input wire [9:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire        tx_chan_start,
  input wire        rx_chan_start,
  input wire        tx_out_valid,
  input wire        tx_out_ready,
  input wire [7:0]  tx_out_data,
  input wire        rx_out_valid,
  input wire        rx_out_ready,
  input wire [7:0]  rx_out_data,
  input wire        tx_channel_block_out,
  input wire        rx_channel_block_out
);
  // ====
  // properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire req = avs_read | avs_write;
  // pending request, then a single accept cycle
  sequence s_take; req && avs_waitrequest; endsequence
  sequence s_ack; !avs_waitrequest ##1 avs_waitrequest; endsequence
  a_bus_answer: assert property (s_take |=> s_ack) else $error("bus request not accepted");
  a_bus_idle: assert property (!req |=> avs_waitrequest) else $error("accept without request");
  a_read_upper: assert property (avs_read && !avs_waitrequest && avs_address[9:6] == 4'h8
    |-> avs_readdata[31:8] == 24'h0) else $error("bank register upper bits set");
  a_tx_blk_hold: assert property (!tx_chan_start |=> $stable(tx_channel_block_out))
    else $error("tx block output moved inside channel time");
  a_rx_blk_hold: assert property (!rx_chan_start |=> $stable(rx_channel_block_out))
    else $error("rx block output moved inside channel time");
  a_tx_out_hold: assert property (tx_out_valid && !tx_out_ready
    |=> tx_out_valid && $stable(tx_out_data)) else $error("tx output dropped while stalled");
  a_rx_out_hold: assert property (rx_out_valid && !rx_out_ready
    |=> rx_out_valid && $stable(rx_out_data)) else $error("rx output dropped while stalled");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("long accept");
endmodule

bind per_channel_idle_and_block_ctrl idle_block_assertions chk_u (.*);

/* File: tb/hdlc_partner.sv */
// serial controller model on the receive stream, clock gated by block out
// assumes clk_sys and active high rst from the bench
`timescale 1ns/10ps
module hdlc_partner (
  input  wire         clk_sys,
  input  wire         rst,
  input  wire         stall_en,
  input  wire         blk,
  input  wire         valid,
  input  wire  [12:0] data,
  output logic        ready,
  output logic [12:0] got,
  output int          cnt,
  output int          ticks
);
  // ====
  // gated clock, low phase only so no glitch
  wire gclk = ~clk_sys & blk;
  // count controller clocks in blocked channels
  always @(posedge gclk or posedge rst)
    ticks <= rst ? 0 : ticks + 1;
  // ready pattern and byte capture
  always @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      ready <= 1'b0;
      got <= 13'h0000; // channel index and byte
      cnt <= 0;
    end
    else
    begin
      ready <= stall_en ? ~ready : 1'b1;
      if (valid && ready)
      begin
        got <= data;
        cnt <= cnt + 1;
      end
    end
endmodule

/* File: tb/per_channel_idle_and_block_ctrl_tb.sv */
// bench: register bus tasks, channel scans, streams through both fifos
// assumes the design top and hdlc_partner are compiled before it
`timescale 1ns/10ps
module per_channel_idle_and_block_ctrl_tb;
  logic clk_sys, rst, avs_read, avs_write, tx_chan_start, rx_chan_start;
  logic tx_in_valid, rx_in_valid, tx_out_ready, stall_en;
  logic [9:0] avs_address;
  logic [31:0] avs_writedata, rd;
  logic [4:0] tx_chan_idx, rx_chan_idx, tx_in_chan, rx_in_chan;
  logic [7:0] tx_in_data, rx_in_data, p;
  logic [12:0] p_got;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, tx_in_ready, tx_out_valid, rx_in_ready, rx_out_valid, rx_out_ready;
  wire [7:0] tx_out_data, rx_out_data;
  wire [4:0] tx_out_chan, rx_out_chan;
  wire tx_channel_block_out, rx_channel_block_out;
  int failures, n_compared, n, i, c, p_cnt, ticks;
  per_channel_idle_and_block_ctrl dut_u (.*);
  hdlc_partner pm_u (.clk_sys, .rst, .stall_en, .blk(rx_channel_block_out), .valid(rx_out_valid),
    .data({rx_out_chan, rx_out_data}), .ready(rx_out_ready), .got(p_got), .cnt(p_cnt), .ticks);
  // ====
  // clock and watchdog
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial
  begin
    #1000000;
    failures++;
    test_done;
  end
  // ====
  // tasks
  function automatic logic [7:0] pat(input int k);
    pat = {k[3:0], ~k[3:0]};
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // a wait that ran out of cycles ends the run as a mismatch
  task give_up(input logic stuck);
    if (stuck)
    begin
      failures++;
      $display("ERROR t=%0t wait limit got=%h exp=%h", $time, 1'b1, 1'b0);
      test_done;
    end
  endtask
  task bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge clk_sys);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, wd};
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (avs_waitrequest && n < 20);
    give_up(avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task rchk(input logic [7:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    chk(rd, {24'h0, e});
  endtask
  task push(input logic rx, input logic [7:0] d, input logic [4:0] ch);
    @(posedge clk_sys);
    if (rx) {rx_in_valid, rx_in_data, rx_in_chan} <= {1'b1, d, ch};
    else {tx_in_valid, tx_in_data, tx_in_chan} <= {1'b1, d, ch};
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (!(rx ? rx_in_ready : tx_in_ready) && n < 20);
    give_up((rx ? rx_in_ready : tx_in_ready) !== 1'b1);
    tx_in_valid <= 1'b0;
    rx_in_valid <= 1'b0;
  endtask
  task pop_tx(input logic [7:0] e, input logic [4:0] ch);
    @(posedge clk_sys);
    tx_out_ready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (!tx_out_valid && n < 20);
    give_up(tx_out_valid !== 1'b1);
    chk({19'h0, tx_out_chan, tx_out_data}, {19'h0, ch, e});
    tx_out_ready <= 1'b0;
  endtask
  task rx_get(input logic [4:0] ch, input logic [7:0] e);
    int c0;
    c0 = p_cnt;
    push(1'b1, 8'h3c, ch);
    n = 0;
    while (p_cnt == c0 && n < 40)
    begin
      @(posedge clk_sys);
      n++;
    end
    give_up(p_cnt == c0);
    chk({19'h0, p_got}, {19'h0, ch, e});
  endtask
  task chan(input logic [4:0] ch);
    @(posedge clk_sys);
    {tx_chan_start, rx_chan_start, tx_chan_idx, rx_chan_idx} <= {2'b11, ch, ch};
    @(posedge clk_sys);
    {tx_chan_start, rx_chan_start} <= 2'b00;
    @(negedge clk_sys);
  endtask
  task test_done;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ====
  // main sequence
  initial
  begin
    {failures, n_compared, stall_en, rst} = {64'h0, 2'b01};
    {avs_read, avs_write, tx_chan_start, rx_chan_start, tx_in_valid, rx_in_valid, tx_out_ready} = 7'h00;
    {avs_address, avs_writedata, tx_chan_idx, rx_chan_idx} = 52'h0;
    {tx_in_data, rx_in_data, tx_in_chan, rx_in_chan} = 26'h0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    for (i = 0; i < 16; i++) rchk(8'(8'h80 + i), 8'h00);
    for (i = 0; i < 16; i++) bus(1'b1, 8'(8'h80 + i), pat(i));
    for (i = 0; i < 16; i++) rchk(8'(8'h80 + i), pat(i));
    bus(1'b1, 8'h40, 8'hff);
    rchk(8'h40, 8'h00);
    // every channel time in E1, then T1 upper channels
    for (c = 0; c < 32; c++)
    begin
      chan(c[4:0]);
      p = pat(8 + c / 8);
      chk({31'h0, rx_channel_block_out}, {31'h0, p[c % 8]});
      p = pat(12 + c / 8);
      chk({31'h0, tx_channel_block_out}, {31'h0, p[c % 8]});
    end
    // two gated clocks per blocked channel, one so far for the last
    @(posedge clk_sys);
    chk(32'(ticks), 32'd31);
    bus(1'b1, 8'h90, 8'h01);
    for (c = 24; c < 32; c++)
    begin
      chan(c[4:0]);
      chk({30'h0, rx_channel_block_out, tx_channel_block_out}, 32'h0);
    end
    rchk(8'h90, 8'h01);
    bus(1'b0, 8'h91, 8'h00);
    chk(rd, 32'h0000_1f1f);
    // idle array, T1 upper channels pass, then E1 all channels
    for (c = 0; c < 64; c++)
    begin
      bus(1'b1, 8'h7e, 8'(c));
      bus(1'b1, 8'h7f, 8'(c) ^ 8'ha5);
    end
    rchk(8'h7f, 8'h9a);
    rchk(8'h7e, 8'h3f);
    stall_en <= 1'b1;
    push(1'b0, 8'h3c, 5'd26);
    pop_tx(8'h3c, 5'd26);
    rx_get(5'd27, 8'h3c);
    bus(1'b1, 8'h90, 8'h00);
    for (c = 0; c < 32; c++)
    begin
      p = pat(c / 8);
      push(1'b0, 8'h3c, c[4:0]);
      pop_tx(p[c % 8] ? 8'(c) ^ 8'ha5 : 8'h3c, c[4:0]);
      p = pat(4 + c / 8);
      rx_get(c[4:0], p[c % 8] ? 8'(c + 32) ^ 8'ha5 : 8'h3c);
    end
    // fill the transmit fifo until refused, then drain in order
    @(posedge clk_sys);
    {tx_in_valid, tx_in_chan, tx_in_data} <= {1'b1, 5'd4, 8'h00};
    i = 0;
    repeat (30)
    begin
      @(posedge clk_sys);
      if (tx_in_ready)
      begin
        i++;
        tx_in_data <= 8'(i);
      end
    end
    tx_in_valid <= 1'b0;
    chk(32'(i), 32'd17);
    for (c = 0; c < 17; c++) pop_tx(8'(c), 5'd4);
    repeat (3) @(posedge clk_sys);
    chk({31'h0, tx_out_valid}, 32'h0);
    test_done;
  end
endmodule
